// ==== verilog/power_down_mode_control.sv ====
// power-down mode control: standby control register, sleep handling,
// processor state pins and module clock stops
// assumes an apb master on pclk and a cpu that pulses sleep_exec and wake_request
`timescale 1ns/1ns
module power_down_mode_control #(
    parameter int MOD_HALF = pdm_pkg::MOD_CLK_HALF
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu events
    input  wire logic        sleep_exec,
    input  wire logic        wake_request,
    // processor state pins
    output logic             proc_state_hi,
    output logic             proc_state_lo,
    // power controls
    output logic             cpu_halt,
    output logic             osc_enable,
    output logic             rtc_regs_access,
    output logic             rtc_counter_run,
    // module clocks
    output logic             timer_clk,
    output logic             rtc_clk,
    output logic             serial_clk,
    output logic             timer_running,
    output logic             rtc_running,
    output logic             serial_running
);

    if (MOD_HALF < 2) begin : g_half_check
        $error("power_down_mode_control: MOD_HALF must be at least 2");
    end

    // apb state
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        access;
    logic        wr_ctrl;
    logic        hit_ctrl;
    logic        hit_status;

    // mode state
    pdm_pkg::standby_control_t ctrl_r;
    pdm_pkg::standby_control_t ctrl_nxt;
    pdm_pkg::power_state_t     state_r;
    pdm_pkg::power_state_t     state_nxt;
    pdm_pkg::status_t          status;
    logic [1:0]                pins_r;
    logic [1:0]                pins_nxt;
    logic                      cpu_halt_r;
    logic                      cpu_halt_nxt;
    logic                      osc_r;
    logic                      osc_nxt;
    logic                      rtc_access_r;
    logic                      rtc_access_nxt;
    logic                      rtc_cnt_r;
    logic                      rtc_cnt_nxt;
    logic                      in_standby;

    // bus decode and answer
    always_comb begin
        hit_ctrl    = (paddr == pdm_pkg::SOFT_STANDBY_SELECT_CTRL_OFF);
        hit_status  = (paddr == pdm_pkg::STATUS_OFF);
        // one wait state: answer in the second access cycle
        access      = psel && penable && !pready_r;
        pready_nxt  = access;
        pslverr_nxt = 1'b0;
        prdata_nxt  = '0;
        if (access) begin
            if (hit_ctrl) begin
                prdata_nxt = {24'h000000, ctrl_r & pdm_pkg::SOFT_STANDBY_SELECT_CTRL_WMASK};
            end else if (hit_status && !pwrite) begin
                prdata_nxt = status;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
        wr_ctrl = psel && penable && pready_r && pwrite && hit_ctrl && pstrb[0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // register and power state next values
    always_comb begin
        ctrl_nxt  = ctrl_r;
        state_nxt = state_r;
        if (wr_ctrl) begin
            ctrl_nxt = pdm_pkg::standby_control_t'(pwdata[7:0] & pdm_pkg::SOFT_STANDBY_SELECT_CTRL_WMASK);
        end
        case (state_r)
            pdm_pkg::PS_NORMAL: begin
                if (sleep_exec) begin
                    state_nxt = ctrl_r.soft_standby_select ? pdm_pkg::PS_STANDBY : pdm_pkg::PS_SLEEP;
                end
            end
            pdm_pkg::PS_SLEEP,
            pdm_pkg::PS_STANDBY: begin
                if (wake_request) begin
                    state_nxt = pdm_pkg::PS_NORMAL;
                end
            end
            default: begin
                state_nxt = pdm_pkg::PS_NORMAL;
            end
        endcase
    end

    // derived controls
    always_comb begin
        in_standby     = (state_r == pdm_pkg::PS_STANDBY);
        pins_nxt       = pdm_pkg::pins_of(state_r);
        cpu_halt_nxt   = (state_r != pdm_pkg::PS_NORMAL);
        osc_nxt        = !in_standby || ctrl_r.crystal_keep_in_standby;
        rtc_access_nxt = !ctrl_r.realtime_clock_gate && rtc_running;
        rtc_cnt_nxt    = osc_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r       <= pdm_pkg::standby_control_t'(pdm_pkg::SOFT_STANDBY_SELECT_CTRL_RESET);
            state_r      <= pdm_pkg::PS_NORMAL;
            pins_r       <= pdm_pkg::PINS_RESET;
            cpu_halt_r   <= 1'b0;
            osc_r        <= 1'b1;
            rtc_access_r <= 1'b0;
            rtc_cnt_r    <= 1'b1;
        end else begin
            ctrl_r       <= ctrl_nxt;
            state_r      <= state_nxt;
            pins_r       <= pins_nxt;
            cpu_halt_r   <= cpu_halt_nxt;
            osc_r        <= osc_nxt;
            rtc_access_r <= rtc_access_nxt;
            rtc_cnt_r    <= rtc_cnt_nxt;
        end
    end

    // a stop bit holds until cleared or reset
    // module clocks; standby also stops all three module clocks, but the rtc counter runs on while the crystal is kept
    // timer clock stop
    module_clock_gate #(.HALF(MOD_HALF)) u_timer_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .stop_req  (ctrl_r.timer_clock_stop || in_standby),
        .mod_clk_r (timer_clk),
        .running_r (timer_running)
    );

    module_clock_gate #(.HALF(MOD_HALF)) u_rtc_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .stop_req  (ctrl_r.realtime_clock_gate || in_standby),
        .mod_clk_r (rtc_clk),
        .running_r (rtc_running)
    );

    module_clock_gate #(.HALF(MOD_HALF)) u_serial_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .stop_req  (ctrl_r.serial_clock_stop || in_standby),
        .mod_clk_r (serial_clk),
        .running_r (serial_running)
    );

    always_comb begin
        status            = '0;
        status.pins       = pins_r;
        status.osc_run    = osc_r;
        status.serial_run = serial_running;
        status.rtc_run    = rtc_running;
        status.timer_run  = timer_running;
        status.rtc_access = rtc_access_r;
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign proc_state_hi   = pins_r[1];
    assign proc_state_lo   = pins_r[0];
    assign cpu_halt        = cpu_halt_r;
    assign osc_enable      = osc_r;
    assign rtc_regs_access = rtc_access_r;
    assign rtc_counter_run = rtc_cnt_r;

    pin_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> {proc_state_hi, proc_state_lo} == pdm_pkg::pins_of($past(state_r)))
        else $error("state pins do not follow power state");

    sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == pdm_pkg::PS_NORMAL && sleep_exec && !ctrl_r.soft_standby_select)
        |=> state_r == pdm_pkg::PS_SLEEP ##1 {proc_state_hi, proc_state_lo} == pdm_pkg::PINS_SLEEP)
        else $error("sleep instruction did not enter sleep");

    standby_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == pdm_pkg::PS_NORMAL && sleep_exec && ctrl_r.soft_standby_select)
        |=> state_r == pdm_pkg::PS_STANDBY ##1 cpu_halt)
        else $error("sleep instruction did not enter standby");

    reg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> ctrl_r == ($past(pwdata[7:0]) & pdm_pkg::SOFT_STANDBY_SELECT_CTRL_WMASK))
        else $error("control register write lost");

    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pslverr && $past(hit_ctrl) |-> prdata[6] == 1'b0 && prdata[5] == 1'b0 && prdata[3] == 1'b0)
        else $error("reserved bit read as one");

    osc_standby_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == pdm_pkg::PS_STANDBY) |=> osc_enable == $past(ctrl_r.crystal_keep_in_standby))
        else $error("oscillator control wrong in standby");

    timer_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.timer_clock_stop [*8] |-> !timer_running && !timer_clk)
        else $error("timer clock still running");

    rtc_access_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.realtime_clock_gate |=> !rtc_regs_access && rtc_counter_run == osc_enable)
        else $error("rtc registers reachable while gated");

    serial_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.serial_clock_stop [*8] |-> !serial_running && !serial_clk)
        else $error("serial clock still running");

    module_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(ctrl_r.timer_clock_stop) && state_r == pdm_pkg::PS_NORMAL && !sleep_exec)
        |-> ##[1:8] timer_running)
        else $error("timer clock did not resume");

    serial_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(ctrl_r.serial_clock_stop) && state_r == pdm_pkg::PS_NORMAL && !sleep_exec)
        |-> ##[1:8] serial_running)
        else $error("serial clock did not resume");

    rtc_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(ctrl_r.realtime_clock_gate) && state_r == pdm_pkg::PS_NORMAL && !sleep_exec)
        |-> ##[1:8] rtc_running)
        else $error("rtc clock did not resume");

    rtc_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.realtime_clock_gate [*8] |-> !rtc_running && !rtc_clk)
        else $error("rtc clock still running");

    osc_normal_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_r != pdm_pkg::PS_STANDBY |=> osc_enable)
        else $error("oscillator stopped outside standby");

    halt_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> cpu_halt == ($past(state_r) != pdm_pkg::PS_NORMAL))
        else $error("cpu halt does not follow power state");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("bus answer held longer than one cycle");

    ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_ctrl |=> $stable(ctrl_r))
        else $error("control register changed without a write");

    reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> ctrl_r == pdm_pkg::SOFT_STANDBY_SELECT_CTRL_RESET
            && {proc_state_hi, proc_state_lo} == pdm_pkg::PINS_RESET)
        else $error("register or pins not at reset value after reset");

endmodule

// ==== verilog/pdm_pkg.sv ====
// constants, field layouts and state types for the power-down mode control block
// assumes a 32-bit apb bus and one 100 MHz clock
package pdm_pkg;

    // register byte offsets
    localparam logic [11:0] SOFT_STANDBY_SELECT_CTRL_OFF   = 12'h000;
    localparam logic [11:0] STATUS_OFF      = 12'h004;

    // standby control register: reset value and writable bits (6, 5, 3 reserved)
    localparam logic [7:0]  SOFT_STANDBY_SELECT_CTRL_RESET = 8'h00;
    localparam logic [7:0]  SOFT_STANDBY_SELECT_CTRL_WMASK = 8'h97;

    // processor state pin codes {hi, lo}
    localparam logic [1:0]  PINS_RESET      = 2'h3;
    localparam logic [1:0]  PINS_SLEEP      = 2'h2;
    localparam logic [1:0]  PINS_STANDBY    = 2'h1;
    localparam logic [1:0]  PINS_NORMAL     = 2'h0;

    // half period of each module clock, in pclk cycles
    localparam int          MOD_CLK_HALF    = 2;

    typedef struct packed {
        logic       soft_standby_select;
        logic [1:0] rsvd_hi;
        logic       crystal_keep_in_standby;
        logic       rsvd_mid;
        logic       timer_clock_stop;
        logic       realtime_clock_gate;
        logic       serial_clock_stop;
    } standby_control_t;

    typedef struct packed {
        logic [24:0] zero;
        logic        rtc_access;
        logic        timer_run;
        logic        rtc_run;
        logic        serial_run;
        logic        osc_run;
        logic [1:0]  pins;
    } status_t;

    typedef enum {
        PS_NORMAL,
        PS_SLEEP,
        PS_STANDBY
    } power_state_t;

    function automatic logic [1:0] pins_of(input power_state_t st);
        case (st)
            PS_SLEEP:   pins_of = PINS_SLEEP;
            PS_STANDBY: pins_of = PINS_STANDBY;
            default:    pins_of = PINS_NORMAL;
        endcase
    endfunction

endpackage

// ==== verilog/module_clock_gate.sv ====
// divided module clock with a glitch-free stop control
// assumes stop requests are synchronous to pclk
`timescale 1ns/1ns
module module_clock_gate #(
    parameter int HALF = pdm_pkg::MOD_CLK_HALF
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic stop_req,
    // module clock
    output logic      mod_clk_r,
    output logic      running_r
);

    if (HALF < 2) begin : g_half_check
        $error("module_clock_gate: HALF must be at least 2");
    end

    localparam int CW = $clog2(HALF);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          mod_clk_nxt;
    logic          running_nxt;
    logic          edge_due;

    always_comb begin
        edge_due    = (cnt_r == CW'(HALF - 1));
        cnt_nxt     = edge_due ? '0 : cnt_r + 1'b1;
        mod_clk_nxt = mod_clk_r;
        running_nxt = running_r;
        if (edge_due) begin
            if (mod_clk_r) begin
                // a high phase always completes
                mod_clk_nxt = 1'b0;
            end else begin
                running_nxt = !stop_req;
                mod_clk_nxt = !stop_req;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r     <= '0;
            mod_clk_r <= 1'b0;
            running_r <= 1'b1;
        end else begin
            cnt_r     <= cnt_nxt;
            mod_clk_r <= mod_clk_nxt;
            running_r <= running_nxt;
        end
    end

    // high phase never shorter than two cycles
    full_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mod_clk_r) |=> mod_clk_r)
        else $error("module clock high phase truncated");

endmodule

// ==== test/state_pin_monitor.sv ====
// partner model: external logic that watches the two processor state pins
// assumes the pins are plain registered levels from the device
`timescale 1ns/1ns
module state_pin_monitor (
    // processor state pins
    input  wire logic       proc_state_hi,
    input  wire logic       proc_state_lo,
    // decoded state, one hot: reset, sleep, standby, normal
    output logic      [3:0] seen_state
);
    always_comb begin
        case ({proc_state_hi, proc_state_lo})
            2'b11:   seen_state = 4'h8;
            2'b10:   seen_state = 4'h4;
            2'b01:   seen_state = 4'h2;
            2'b00:   seen_state = 4'h1;
            // an unknown pin level decodes to nothing, so it never matches
            default: seen_state = 4'h0;
        endcase
    end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the power-down mode control block
// assumes the apb slave answers after one wait cycle and pclk runs at 100 MHz
`timescale 1ns/1ns
module tb;
    typedef struct {logic [7:0] wr; logic [7:0] exp;} row_t;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf, seen_state;
    logic        pready, pslverr, err, sleep_exec = 1'b0, wake_request = 1'b0;
    logic        proc_state_hi, proc_state_lo, cpu_halt, osc_enable, rtc_regs_access, rtc_counter_run;
    logic        timer_clk, rtc_clk, serial_clk, timer_running, rtc_running, serial_running;
    logic [2:0]  tg;
    int          miscompares = 0, compares = 0;
    // software keeps the reserved bits at zero
    row_t        rows[6] = '{'{8'h97, 8'h97}, '{8'h10, 8'h10}, '{8'h05, 8'h05},
                             '{8'h12, 8'h12}, '{8'h80, 8'h80}, '{8'h00, 8'h00}};

    always #5 pclk = ~pclk;

    power_down_mode_control power_down_mode_control_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec), .wake_request(wake_request),
        .proc_state_hi(proc_state_hi), .proc_state_lo(proc_state_lo), .cpu_halt(cpu_halt),
        .osc_enable(osc_enable), .rtc_regs_access(rtc_regs_access), .rtc_counter_run(rtc_counter_run),
        .timer_clk(timer_clk), .rtc_clk(rtc_clk), .serial_clk(serial_clk), .timer_running(timer_running),
        .rtc_running(rtc_running), .serial_running(serial_running));
    state_pin_monitor state_pin_monitor_inst (.proc_state_hi(proc_state_hi), .proc_state_lo(proc_state_lo),
        .seen_state(seen_state));

    task automatic test_done;
        $display("checks %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is sampled high; a hung slave ends the run
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            miscompares++;
            test_done();
        end
    endtask

    task automatic pulse(input logic wake);
        @(posedge pclk);
        if (wake) wake_request <= 1'b1;
        else sleep_exec <= 1'b1;
        @(posedge pclk);
        wake_request <= 1'b0;
        sleep_exec   <= 1'b0;
    endtask

    task automatic wait_state(input logic [3:0] exp);
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (seen_state === exp) break;
        end
        chk("state", seen_state, exp);
        if (seen_state !== exp) test_done();
    endtask

    // which module clocks toggled over 16 cycles
    task automatic toggles;
        logic [2:0] prev;
        tg   = 3'h0;
        prev = {timer_clk, rtc_clk, serial_clk};
        repeat (16) begin
            @(posedge pclk);
            tg   = tg | (prev ^ {timer_clk, rtc_clk, serial_clk});
            prev = {timer_clk, rtc_clk, serial_clk};
        end
    endtask

    task automatic standby(input logic [7:0] ctl);
        apb(1'b1, 12'h000, {24'h0, ctl}, 4'hf);
        pulse(1'b0);
        wait_state(4'h2);
        repeat (12) @(posedge pclk);
        chk("osc", osc_enable, ctl[4]);
        chk("rtc_count", rtc_counter_run, ctl[4]);
        chk("halt", cpu_halt, 1'b1);
        toggles();
        chk("standby_clks", tg, 3'h0);
        pulse(1'b1);
        wait_state(4'h1);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        chk("reset_state", seen_state, 4'h8);
        presetn <= 1'b1;
        foreach (rows[k]) begin
            apb(1'b1, 12'h000, {24'h0, rows[k].wr}, 4'hf);
            apb(1'b0, 12'h000, 32'h0, 4'hf);
            chk("ctrl", rd, {24'h0, rows[k].exp});
            repeat (10) @(posedge pclk);
            toggles();
            chk("mod_clks", tg, 3'(~rows[k].exp[2:0]));
            chk("running", {timer_running, rtc_running, serial_running}, 3'(~rows[k].exp[2:0]));
            chk("rtc_access", rtc_regs_access, !rows[k].exp[1]);
            chk("rtc_count", rtc_counter_run, 1'b1);
            apb(1'b0, 12'h004, 32'h0, 4'hf);
            chk("status", rd, {25'h0, ~rows[k].exp[1], ~rows[k].exp[2:0], 3'h4});
        end
        apb(1'b0, 12'h008, 32'h0, 4'hf);
        chk("unmapped_err", err, 1'b1);
        apb(1'b1, 12'h000, 32'h17, 4'h0);
        apb(1'b1, 12'h004, 32'hff, 4'hf);
        chk("ro_err", err, 1'b1);
        apb(1'b0, 12'h000, 32'h0, 4'hf);
        chk("ctrl_kept", rd, 32'h0);
        apb(1'b1, 12'h000, 32'h0, 4'hf);
        pulse(1'b0);
        wait_state(4'h4);
        chk("halt", cpu_halt, 1'b1);
        pulse(1'b0);
        pulse(1'b1);
        wait_state(4'h1);
        standby(8'h80);
        standby(8'h90);
        apb(1'b1, 12'h000, 32'h97, 4'hf);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("reset_state", seen_state, 4'h8);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 4'hf);
        chk("ctrl_reset", rd, 32'h0);
        test_done();
    end
endmodule
